// ### pkg/tpw_regs.svh
// constant map of the timer, pulse and watchdog unit: offsets, fields, resets
// assumes a cpu core that drives a page bit, a 4-bit offset and byte strobes
// What this block does
// - counter one is an 8-bit prescaled down-counter with readable, writable preset
// - counter one reloads its preset by itself after each interrupt and keeps counting
// - counter two is an 8-bit prescaled down-counter reloading its readable preset
// - with infrared on, counter two gives carrier of clock/(2*(preset+1)*prescale)
// - high-pulse timer holds output high prescale*(preset+1) clock periods
// - low-pulse timer holds output low prescale*(preset+1) clock periods
// - mask bits 7..0 enable input change, low, high, cnt2, cnt1, ext1, ext0, overflow
// - four active-low wake enables gate pin change per port nibble
// - wake-up starts enabled; software keeps monitored pins from floating
// - wake register bit 7 selects normal or doubled infrared pin sink current
// - time-base control bit 7 picks rising or falling edge of external irq zero
// - time-base control bit 6 reads the global interrupt enable, read only
// - bit 5 picks instruction clock or counter pin; pin slower than instruction clock
// - bit 4 picks the counter pin edge, rising at 0 and falling at 1
// - prescaler off gives 1:1, on gives 1:2^(n+1)
// - watchdog control bit 3 enables the watchdog; bits 7..4 unused
// - watchdog runs from sub oscillator halved, then prescaled 1:2^n
// - counter control bit 7 picks counter two clock, bits 6..4 its prescale
// - counter control bit 3 picks counter one clock, bits 2..0 its prescale
// - data window moves bytes to and from 128-byte ram at the held address
// - page bit 0 picks register page; page 1 holds control registers
// - ram address register is 7 bits, top bit reads zero
// - each underflow and the overflow set a flag; its mask bit gates only irq pending
// - modulation on puts carrier in low sections; off, counter two runs alone
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH
// page 0 offsets
`define TPW_OFF_RAM_ADDR 4'h9
`define TPW_OFF_RAM_DATA 4'hA
`define TPW_OFF_CNT1_PRESET 4'hB
`define TPW_OFF_CNT2_PRESET 4'hC
`define TPW_OFF_HIGH_PRESET 4'hD
`define TPW_OFF_LOW_PRESET 4'hE
`define TPW_OFF_IRQ_MASK 4'hF
// page 1 offsets
`define TPW_OFF_WAKE_CTRL 4'h6
`define TPW_OFF_BASE_CTRL 4'h7
`define TPW_OFF_WDOG_CTRL 4'h8
`define TPW_OFF_CNT_CTRL 4'h9
`define TPW_OFF_PULSE_CTRL 4'hA
// field positions
`define TPW_BIT_IR_STRONG 7
`define TPW_BIT_EXTERNAL_IRQ_ZERO_EDGE 7
`define TPW_BIT_GIE 6
`define TPW_BIT_BASE_SRC 5
`define TPW_BIT_PIN_EDGE 4
`define TPW_BIT_PRESC_ON 3
`define TPW_BIT_WDOG_ON 3
// flag / mask bit positions
`define TPW_FLAG_BASE 0
`define TPW_FLAG_EXT0 1
`define TPW_FLAG_EXT1 2
`define TPW_FLAG_CNT1 3
`define TPW_FLAG_CNT2 4
`define TPW_FLAG_HIGH 5
`define TPW_FLAG_LOW 6
`define TPW_FLAG_CHANGE 7
// reset values
`define TPW_RST_WAKE_CTRL 8'h00
`define TPW_RST_BASE_CTRL 8'hBF
`define TPW_RST_ZERO 8'h00
// watchdog timeout length in prescaled ticks
`define TPW_WDOG_SPAN 9'h100
`endif

// ### pkg/tpw_pkg.sv
// types shared by the timer, pulse and watchdog unit
// assumes nothing beyond the constant header
package tpw_pkg;
	typedef enum logic [1:0] {
		TPW_PH_IDLE,
		TPW_PH_HIGH,
		TPW_PH_LOW
	} tpw_phase_t;
	typedef logic [7:0] tpw_byte_t;
endpackage

// ### hdl/tpw_unit.sv
// timer, pulse-width and watchdog unit with paged control registers and window ram
// assumes oscillator and instruction ticks are one-cycle pulses on clock_i
// and that the core drives page select and strobes on clock_i
`include "tpw_regs.svh"
module tpw_unit import tpw_pkg::*; #(
	parameter int RAM_DEPTH = 128,
	parameter int NCH = 4
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic page_sel_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic main_tick_i,
	input wire logic sub_tick_i,
	input wire logic instr_tick_i,
	input wire logic gie_i,
	input wire logic [1:0] counter_run_i,
	input wire logic ir_enable_i,
	input wire logic carrier_modulation_on_i,
	input wire logic low_only_i,
	input wire logic base_pin_i,
	input wire logic ext_irq_zero_pin_i,
	input wire logic ext_irq_one_pin_i,
	input wire logic [15:0] change_pins_i,
	input wire logic [7:0] flag_clear_i,
	input wire logic wdog_clear_i,
	output logic [7:0] irq_flags_o,
	output logic irq_pending_o,
	output logic wake_o,
	output logic infrared_output_pin_o,
	output logic ir_pin_drive_strength_o,
	output logic [7:0] time_base_counter_o,
	output logic wdog_reset_o
);
	// ****************************************
	// register file
	// ****************************************
	tpw_byte_t wake_q, base_q, wdog_q, cnt_ctrl_q, pulse_ctrl_q, mask_q;
	tpw_byte_t preset_q [NCH];
	logic [6:0] ram_addr_q;
	tpw_byte_t ram_q [RAM_DEPTH];
	tpw_byte_t rdata_q;
	logic [7:0] flags_q;
	logic wr_p0, wr_p1;

	assign wr_p0 = reg_wr_i && !page_sel_i;
	assign wr_p1 = reg_wr_i && page_sel_i;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_q <= `TPW_RST_WAKE_CTRL;
			base_q <= `TPW_RST_BASE_CTRL;
			wdog_q <= `TPW_RST_ZERO;
			cnt_ctrl_q <= `TPW_RST_ZERO;
			pulse_ctrl_q <= `TPW_RST_ZERO;
			mask_q <= `TPW_RST_ZERO;
			ram_addr_q <= 7'h00;
		end else begin
			if (wr_p1) begin
				unique case (reg_addr_i)
					`TPW_OFF_WAKE_CTRL: wake_q <= reg_wdata_i & 8'h8F;
					`TPW_OFF_BASE_CTRL: base_q <= reg_wdata_i & 8'hBF;
					`TPW_OFF_WDOG_CTRL: wdog_q <= reg_wdata_i & 8'h0F;
					`TPW_OFF_CNT_CTRL: cnt_ctrl_q <= reg_wdata_i;
					`TPW_OFF_PULSE_CTRL: pulse_ctrl_q <= reg_wdata_i;
					default: ;
				endcase
			end
			if (wr_p0) begin
				unique case (reg_addr_i)
					`TPW_OFF_RAM_ADDR: ram_addr_q <= reg_wdata_i[6:0];
					`TPW_OFF_IRQ_MASK: mask_q <= reg_wdata_i;
					default: ;
				endcase
			end
		end
	end

	// presets: a write changes only the reload value
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NCH; i++) begin
				preset_q[i] <= `TPW_RST_ZERO;
			end
		end else if (wr_p0) begin
			unique case (reg_addr_i)
				`TPW_OFF_CNT1_PRESET: preset_q[0] <= reg_wdata_i;
				`TPW_OFF_CNT2_PRESET: preset_q[1] <= reg_wdata_i;
				`TPW_OFF_HIGH_PRESET: preset_q[2] <= reg_wdata_i;
				`TPW_OFF_LOW_PRESET: preset_q[3] <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// window ram: no reset, contents are undefined at power-up
	always_ff @(posedge clock_i) begin
		if (wr_p0 && reg_addr_i == `TPW_OFF_RAM_DATA) begin
			ram_q[ram_addr_q] <= reg_wdata_i;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			if (page_sel_i) begin
				unique case (reg_addr_i)
					`TPW_OFF_WAKE_CTRL: rdata_q <= wake_q;
					`TPW_OFF_BASE_CTRL: rdata_q <= {base_q[7], gie_i, base_q[5:0]};
					`TPW_OFF_WDOG_CTRL: rdata_q <= wdog_q;
					`TPW_OFF_CNT_CTRL: rdata_q <= cnt_ctrl_q;
					`TPW_OFF_PULSE_CTRL: rdata_q <= pulse_ctrl_q;
					default: rdata_q <= 8'h00;
				endcase
			end else begin
				unique case (reg_addr_i)
					`TPW_OFF_RAM_ADDR: rdata_q <= {1'b0, ram_addr_q};
					`TPW_OFF_RAM_DATA: rdata_q <= ram_q[ram_addr_q];
					`TPW_OFF_CNT1_PRESET: rdata_q <= preset_q[0];
					`TPW_OFF_CNT2_PRESET: rdata_q <= preset_q[1];
					`TPW_OFF_HIGH_PRESET: rdata_q <= preset_q[2];
					`TPW_OFF_LOW_PRESET: rdata_q <= preset_q[3];
					`TPW_OFF_IRQ_MASK: rdata_q <= mask_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end
	assign reg_rdata_o = rdata_q;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [18:0] pin_s1_q, pin_s2_q, pin_s3_q;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1_q <= 19'h0_0000;
			pin_s2_q <= 19'h0_0000;
			pin_s3_q <= 19'h0_0000;
		end else begin
			pin_s1_q <= {change_pins_i, ext_irq_one_pin_i, ext_irq_zero_pin_i, base_pin_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	logic [18:0] rise, fall;
	assign rise = pin_s2_q & ~pin_s3_q;
	assign fall = ~pin_s2_q & pin_s3_q;

	// ****************************************
	// time-base counter
	// ****************************************
	logic [7:0] tb_presc_q, tb_cnt_q;
	logic [8:0] tb_ratio;
	logic tb_src, tb_tick, tb_ovf;
	assign tb_src = base_q[`TPW_BIT_BASE_SRC] ?
		(base_q[`TPW_BIT_PIN_EDGE] ? fall[0] : rise[0]) : instr_tick_i;
	assign tb_ratio = base_q[`TPW_BIT_PRESC_ON] ?
		(9'h002 << base_q[2:0]) : 9'h001;
	// a count left above a lowered ratio ticks at once instead of wrapping
	assign tb_tick = tb_src && ({1'b0, tb_presc_q} >= tb_ratio - 9'h001);
	assign tb_ovf = tb_tick && (tb_cnt_q == 8'hFF);
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tb_presc_q <= 8'h00;
			tb_cnt_q <= 8'h00;
		end else if (tb_src) begin
			tb_presc_q <= tb_tick ? 8'h00 : tb_presc_q + 8'h01;
			if (tb_tick) begin
				tb_cnt_q <= tb_cnt_q + 8'h01;
			end
		end
	end
	assign time_base_counter_o = tb_cnt_q;

	// ****************************************
	// auxiliary down-counters: 0 cnt1, 1 cnt2, 2 high, 3 low
	// ****************************************
	tpw_phase_t phase_q;
	logic [NCH-1:0] ch_run, ch_uf;
	logic [3:0] ch_cfg [NCH];
	assign ch_cfg[0] = cnt_ctrl_q[3:0];
	assign ch_cfg[1] = cnt_ctrl_q[7:4];
	assign ch_cfg[2] = pulse_ctrl_q[3:0];
	assign ch_cfg[3] = pulse_ctrl_q[7:4];
	assign ch_run[0] = counter_run_i[0];
	assign ch_run[1] = counter_run_i[1] || (ir_enable_i && carrier_modulation_on_i);
	assign ch_run[2] = ir_enable_i && !low_only_i && phase_q == TPW_PH_HIGH;
	assign ch_run[3] = ir_enable_i && (low_only_i || phase_q == TPW_PH_LOW);

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [7:0] presc_q, cnt_q;
		logic src, tick;
		assign src = ch_cfg[c][3] ? main_tick_i : sub_tick_i;
		assign tick = ch_run[c] && src &&
			({1'b0, presc_q} == (9'h002 << ch_cfg[c][2:0]) - 9'h001);
		assign ch_uf[c] = tick && cnt_q == 8'h00;
		always_ff @(posedge clock_i or negedge nrst_i) begin
			if (!nrst_i) begin
				presc_q <= 8'h00;
				cnt_q <= 8'h00;
			end else if (!ch_run[c]) begin
				presc_q <= 8'h00;
				cnt_q <= preset_q[c];
			end else if (src) begin
				presc_q <= tick ? 8'h00 : presc_q + 8'h01;
				if (tick) begin
					cnt_q <= (cnt_q == 8'h00) ? preset_q[c] : cnt_q - 8'h01;
				end
			end
		end
	end

	// ****************************************
	// pulse shaping and carrier
	// ****************************************
	logic carrier_q, ir_q;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			carrier_q <= 1'b0;
		end else if (!ch_run[1]) begin
			carrier_q <= 1'b0;
		end else if (ch_uf[1]) begin
			carrier_q <= !carrier_q;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_q <= TPW_PH_IDLE;
		end else if (!ir_enable_i) begin
			phase_q <= TPW_PH_IDLE;
		end else begin
			unique case (phase_q)
				TPW_PH_IDLE: phase_q <= TPW_PH_HIGH;
				TPW_PH_HIGH: if (ch_uf[2] || low_only_i) phase_q <= TPW_PH_LOW;
				TPW_PH_LOW: if (ch_uf[3] && !low_only_i) phase_q <= TPW_PH_HIGH;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ir_q <= 1'b0;
		end else if (!ir_enable_i) begin
			ir_q <= 1'b0;
		end else if (low_only_i) begin
			if (ch_uf[3]) begin
				ir_q <= !ir_q;
			end
		end else if (phase_q == TPW_PH_HIGH) begin
			ir_q <= 1'b1;
		end else if (phase_q == TPW_PH_LOW) begin
			ir_q <= carrier_modulation_on_i ? carrier_q : 1'b0;
		end else begin
			ir_q <= 1'b0;
		end
	end
	assign infrared_output_pin_o = ir_q;
	assign ir_pin_drive_strength_o = wake_q[`TPW_BIT_IR_STRONG];

	// ****************************************
	// flags, mask and wake
	// ****************************************
	logic [7:0] set_ev;
	logic [3:0] nib_chg;
	logic pend_q, wake_q_o;
	for (genvar n = 0; n < 4; n++) begin : g_nib
		assign nib_chg[n] = |(rise[3+4*n +: 4] | fall[3+4*n +: 4]);
	end
	assign set_ev[`TPW_FLAG_BASE] = tb_ovf;
	assign set_ev[`TPW_FLAG_EXT0] = base_q[`TPW_BIT_EXTERNAL_IRQ_ZERO_EDGE] ? fall[1] : rise[1];
	assign set_ev[`TPW_FLAG_EXT1] = rise[2];
	assign set_ev[`TPW_FLAG_CNT1] = ch_uf[0];
	assign set_ev[`TPW_FLAG_CNT2] = ch_uf[1];
	assign set_ev[`TPW_FLAG_HIGH] = ch_uf[2];
	assign set_ev[`TPW_FLAG_LOW] = ch_uf[3];
	assign set_ev[`TPW_FLAG_CHANGE] = |nib_chg;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_q <= 8'h00;
			pend_q <= 1'b0;
			wake_q_o <= 1'b0;
		end else begin
			flags_q <= (flags_q & ~flag_clear_i) | set_ev; // set wins over clear
			pend_q <= |(flags_q & mask_q);
			wake_q_o <= |(nib_chg & ~wake_q[3:0]);
		end
	end
	assign irq_flags_o = flags_q;
	assign irq_pending_o = pend_q;
	assign wake_o = wake_q_o;

	// ****************************************
	// watchdog on sub oscillator
	// ****************************************
	logic wd_half_q, wd_tick;
	logic [6:0] wd_presc_q;
	logic [8:0] wd_cnt_q;
	logic wd_rst_q;
	assign wd_tick = sub_tick_i && wd_half_q &&
		({1'b0, wd_presc_q} >= (8'h01 << wdog_q[2:0]) - 8'h01);
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_half_q <= 1'b0;
			wd_presc_q <= 7'h00;
			wd_cnt_q <= 9'h000;
			wd_rst_q <= 1'b0;
		end else if (!wdog_q[`TPW_BIT_WDOG_ON] || wdog_clear_i) begin
			wd_half_q <= 1'b0;
			wd_presc_q <= 7'h00;
			wd_cnt_q <= 9'h000;
			wd_rst_q <= 1'b0;
		end else begin
			wd_rst_q <= 1'b0;
			if (sub_tick_i) begin
				wd_half_q <= !wd_half_q;
				if (wd_half_q) begin
					wd_presc_q <= wd_tick ? 7'h00 : wd_presc_q + 7'h01;
				end
			end
			if (wd_tick) begin
				if (wd_cnt_q == `TPW_WDOG_SPAN - 9'h001) begin
					wd_cnt_q <= 9'h000;
					wd_rst_q <= 1'b1;
				end else begin
					wd_cnt_q <= wd_cnt_q + 9'h001;
				end
			end
		end
	end
	assign wdog_reset_o = wd_rst_q;
endmodule

// ### sim/tpw_unit_sva.sv
// checker of the timer, pulse and watchdog unit, watching top ports only
// assumes register strobes, page and offset are sampled on rising clock_i
module tpw_unit_sva import tpw_pkg::*; (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic page_sel_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic gie_i,
	input wire logic [7:0] flag_clear_i,
	input wire logic [7:0] irq_flags_o,
	input wire logic irq_pending_o,
	input wire logic ir_pin_drive_strength_o,
	input wire logic [7:0] time_base_counter_o,
	input wire logic wdog_reset_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// shadow of written control bits
	// ****
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	tpw_byte_t mask_q;
	logic strong_q;
	logic wdog_on_q;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mask_q <= 8'h00;
			strong_q <= 1'b0;
			wdog_on_q <= 1'b0;
		end else if (reg_wr_i) begin
			if (!page_sel_i && reg_addr_i == 4'hf) mask_q <= reg_wdata_i;
			if (page_sel_i && reg_addr_i == 4'h6) strong_q <= reg_wdata_i[7];
			if (page_sel_i && reg_addr_i == 4'h8) wdog_on_q <= reg_wdata_i[3];
		end
	end
	sequence s_rd(p, a);
		reg_rd_i && page_sel_i == p && reg_addr_i == a;
	endsequence
	sequence s_unmapped;
		reg_rd_i && (page_sel_i ? (reg_addr_i < 4'h6 || reg_addr_i > 4'ha) : reg_addr_i < 4'h9);
	endsequence
	property p_addr_top;
		s_rd(1'b0, 4'h9) |=> reg_rdata_o[7] == 1'b0;
	endproperty
	a_addr_top: assert property (p_addr_top) else $error("ram address top bit set");
	property p_unmapped;
		s_unmapped |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_gie;
		s_rd(1'b1, 4'h7) |=> reg_rdata_o[6] == $past(gie_i);
	endproperty
	a_gie: assert property (p_gie) else $error("enable flag not shown");
	property p_wake_unused;
		s_rd(1'b1, 4'h6) |=> reg_rdata_o[6:4] == 3'h0;
	endproperty
	a_wake_unused: assert property (p_wake_unused) else $error("wake unused bits set");
	property p_wdog_unused;
		s_rd(1'b1, 4'h8) |=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_wdog_unused: assert property (p_wdog_unused) else $error("watchdog unused bits");
	property p_pending;
		1'b1 |=> irq_pending_o == |($past(irq_flags_o) & $past(mask_q));
	endproperty
	a_pending: assert property (p_pending) else $error("pending not flags and mask");
	property p_sticky;
		1'b1 |=> ($past(irq_flags_o) & ~$past(flag_clear_i) & ~irq_flags_o) == 8'h00;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");
	property p_wdog_pulse;
		wdog_reset_o |=> !wdog_reset_o;
	endproperty
	a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog pulse too long");
	property p_wdog_off;
		!wdog_on_q && !$past(wdog_on_q) |-> !wdog_reset_o;
	endproperty
	a_wdog_off: assert property (p_wdog_off) else $error("watchdog fired while off");
	property p_strength;
		ir_pin_drive_strength_o == strong_q;
	endproperty
	a_strength: assert property (p_strength) else $error("drive select wrong");
	property p_base_step;
		$changed(time_base_counter_o) |-> time_base_counter_o == $past(time_base_counter_o) + 8'h01;
	endproperty
	a_base_step: assert property (p_base_step) else $error("time base jumped");
endmodule
bind tpw_unit tpw_unit_sva u_sva (.clock_i, .nrst_i, .page_sel_i, .reg_addr_i, .reg_wr_i,
	.reg_rd_i, .reg_wdata_i, .reg_rdata_o, .gie_i, .flag_clear_i, .irq_flags_o, .irq_pending_o,
	.ir_pin_drive_strength_o, .time_base_counter_o, .wdog_reset_o);

// ### sim/tpw_core_model.sv
// core-side model issuing paged register accesses to the unit
// assumes callers enter its tasks at a falling edge of clock_i
module tpw_core_model (
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	output logic page_o,
	output logic [3:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// one strobe per access, a spare edge between accesses
	// ****
	initial {page_o, addr_o, wr_o, rd_o, wdata_o} = '0;
	task automatic wr(input logic p, input logic [3:0] a, input logic [7:0] d);
		@(negedge clock_i);
		page_o = p;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clock_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic p, input logic [3:0] a, output logic [7:0] d);
		@(negedge clock_i);
		page_o = p;
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clock_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule

// ### sim/timer_pulse_and_watchdog_unit_bench.sv
// self-checking bench of the timer, pulse and watchdog unit
// assumes the core model drives the register bus and the checker is bound
`include "tpw_regs.svh"
module timer_pulse_and_watchdog_unit_bench import tpw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// signals, reference model, tasks
	// ****
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic main_tick_i = 1'b0;
	logic page_sel_i, reg_wr_i, reg_rd_i, gie_i, ir_enable_i, low_only_i;
	logic carrier_modulation_on_i, base_pin_i, ext_irq_zero_pin_i, irq_pending_o, wake_o;
	logic ext_irq_one_pin_i;
	logic infrared_output_pin_o, ir_pin_drive_strength_o, wdog_reset_o;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, irq_flags_o, flag_clear_i, time_base_counter_o;
	logic [1:0] counter_run_i;
	logic [15:0] change_pins_i;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 32'h01dd_48a2;
	int mdl[32];
	int ram_m[128];
	int aq[$];
	logic [3:0] ad[12] = '{4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'h3};
	logic [7:0] mk[12] = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h8f, 8'hbf, 8'h0f,
		8'hff, 8'hff, 8'h00};
	tpw_unit u_dut (.clock_i, .nrst_i, .page_sel_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .main_tick_i, .sub_tick_i(1'b1), .instr_tick_i(1'b1), .gie_i,
		.counter_run_i, .ir_enable_i, .carrier_modulation_on_i, .low_only_i, .base_pin_i,
		.ext_irq_zero_pin_i, .ext_irq_one_pin_i, .change_pins_i, .flag_clear_i,
		.wdog_clear_i(1'b0), .irq_flags_o, .irq_pending_o, .wake_o, .infrared_output_pin_o,
		.ir_pin_drive_strength_o, .time_base_counter_o, .wdog_reset_o);
	tpw_core_model u_core (.clock_i, .rdata_i(reg_rdata_o), .page_o(page_sel_i),
		.addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
	always #25 clock_i = ~clock_i;
	always @(negedge clock_i) main_tick_i <= ~main_tick_i;
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic clr();
		flag_clear_i = 8'hff;
		cyc(1);
		flag_clear_i = 8'h00;
	endtask
	// cycles until flag b shows again, clearing it first
	task automatic period(input int b, output int n);
		n = 0;
		flag_clear_i[b] = 1'b1;
		do begin
			@(negedge clock_i);
			flag_clear_i = 8'h00;
			n++;
		end while (irq_flags_o[b] !== 1'b1 && n < 3000);
	endtask
	task automatic gap(output int n);
		logic v;
		v = infrared_output_pin_o;
		n = 0;
		do begin
			@(negedge clock_i);
			n++;
		end while (infrared_output_pin_o === v && n < 3000);
	endtask
	task automatic wpulse(output int n);
		n = 0;
		do begin
			@(negedge clock_i);
			n++;
		end while (wdog_reset_o !== 1'b1 && n < 3000);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		int n, p, c, s;
		logic [7:0] d;
		{gie_i, ir_enable_i, carrier_modulation_on_i, low_only_i, base_pin_i} = '0;
		{ext_irq_zero_pin_i, ext_irq_one_pin_i, counter_run_i, flag_clear_i} = '0;
		change_pins_i = 16'h0000;
		cyc(2);
		nrst_i = 1'b1;
		u_core.rd(1'b1, 4'h6, d);
		chk(d, `TPW_RST_WAKE_CTRL);
		u_core.rd(1'b1, 4'h7, d);
		chk(d, `TPW_RST_BASE_CTRL);
		gie_i = 1'b1;
		for (int i = 0; i < 12; i++) begin
			p = $random(seed) & 255;
			u_core.wr(i > 5, ad[i], p[7:0]);
			mdl[{i > 5, ad[i]}] = p & mk[i];
		end
		for (int i = 0; i < 12; i++) begin
			u_core.rd(i > 5, ad[i], d);
			chk(d, mdl[{i > 5, ad[i]}] | (i == 7 ? 8'h40 : 8'h00));
		end
		for (int i = 0; i < 4; i++) begin
			aq.push_back(i == 3 ? 127 : $random(seed) & 127);
			ram_m[aq[i]] = $random(seed) & 255;
			u_core.wr(1'b0, 4'h9, 8'(aq[i]));
			u_core.wr(1'b0, 4'ha, 8'(ram_m[aq[i]]));
		end
		foreach (aq[i]) begin
			u_core.wr(1'b0, 4'h9, 8'(aq[i]));
			u_core.rd(1'b0, 4'ha, d);
			chk(d, ram_m[aq[i]]);
		end
		$display("done: registers and ram window");
		for (int k = 0; k < 2; k++) begin
			// preset of at least one keeps the preset rewrite ahead of the next reload
			p = 1 + ($random(seed) & 6);
			s = $random(seed) & 1;
			c = $random(seed) & 1;
			u_core.wr(1'b1, 4'h9, 8'((s * 8 + c) << (4 * k)));
			u_core.wr(1'b0, 4'(11 + k), 8'(p));
			counter_run_i[k] = 1'b1;
			period(3 + k, n);
			fork
				u_core.wr(1'b0, 4'(11 + k), 8'(p + 3));
				period(3 + k, n);
			join
			chk(n, (p + 1) * (2 << c) * (s + 1));
			period(3 + k, n);
			chk(n, (p + 4) * (2 << c) * (s + 1));
			counter_run_i[k] = 1'b0;
		end
		$display("done: counters");
		u_core.wr(1'b1, 4'ha, 8'h00);
		p = $random(seed) & 7;
		s = $random(seed) & 7;
		u_core.wr(1'b0, 4'hd, 8'(p));
		u_core.wr(1'b0, 4'he, 8'(s));
		ir_enable_i = 1'b1;
		for (int k = 0; k < 2; k++) begin
			low_only_i = k[0];
			cyc(40);
			do gap(n); while (infrared_output_pin_o !== 1'b1);
			gap(n);
			chk(n, k ? (s + 1) * 2 : (p + 1) * 2);
			gap(n);
			chk(n, (s + 1) * 2);
		end
		low_only_i = 1'b0;
		u_core.wr(1'b1, 4'h9, 8'h00);
		u_core.wr(1'b0, 4'hc, 8'h01);
		u_core.wr(1'b0, 4'hd, 8'h0f);
		u_core.wr(1'b0, 4'he, 8'h1f);
		counter_run_i[1] = 1'b1;
		carrier_modulation_on_i = 1'b1;
		do gap(n); while (!(n > 8 && infrared_output_pin_o === 1'b0));
		gap(n);
		gap(n);
		chk(n, 4);
		gap(n);
		chk(n, 4);
		{ir_enable_i, carrier_modulation_on_i, counter_run_i} = '0;
		$display("done: pulse output and carrier");
		for (c = 0; c < 9; c++) begin
			u_core.wr(1'b1, 4'h7, c == 0 ? 8'h00 : 8'(7 + c));
			cyc((1 << c) + 4);
			d = time_base_counter_o;
			cyc(2 << c);
			chk(time_base_counter_o, 8'(d + 2));
		end
		for (int k = 0; k < 2; k++) begin
			u_core.wr(1'b1, 4'h7, 8'(32 + 16 * k));
			cyc(8);
			d = time_base_counter_o;
			base_pin_i = 1'b1;
			cyc(8);
			chk(time_base_counter_o, 8'(d + 1 - k));
			base_pin_i = 1'b0;
			cyc(8);
			chk(time_base_counter_o, 8'(d + 1));
		end
		for (int k = 0; k < 2; k++) begin
			u_core.wr(1'b1, 4'h7, 8'(128 * k));
			clr();
			ext_irq_zero_pin_i = 1'b1;
			ext_irq_one_pin_i = 1'b1;
			cyc(8);
			chk(irq_flags_o[1], 1 - k);
			chk(irq_flags_o[2], 1'b1);
			clr();
			ext_irq_zero_pin_i = 1'b0;
			ext_irq_one_pin_i = 1'b0;
			cyc(8);
			chk(irq_flags_o[1], k);
			chk(irq_flags_o[2], 1'b0);
		end
		$display("done: time base and external edge");
		for (int k = 0; k < 4; k++) begin
			u_core.wr(1'b1, 4'h6, {k[0], 3'h0, 4'hf ^ 4'(1 << k)});
			chk(ir_pin_drive_strength_o, k[0]);
			for (int j = 1; j >= 0; j--) begin
				n = 0;
				change_pins_i[4 * ((k + j) % 4)] ^= 1'b1;
				repeat (8) begin
					@(negedge clock_i);
					n += wake_o;
				end
				chk(n, 1 - j);
			end
		end
		$display("done: wake enables");
		for (c = 0; c < 2; c++) begin
			u_core.wr(1'b1, 4'h8, 8'(8 + c));
			wpulse(n);
			wpulse(n);
			chk(n, 512 << c);
		end
		u_core.wr(1'b1, 4'h8, 8'h00);
		n = 0;
		repeat (1200) begin
			@(negedge clock_i);
			n += wdog_reset_o;
		end
		chk(n, 0);
		$display("done: watchdog");
		summarize();
	end
endmodule
